// ==== verilog/dual_timer_pkg.sv ====
// Constants, register map and field layout of the dual timer/counter
// Function
// - Two independent 16-bit timer/counter channels
// - Timer mode counts once per 12 clocks
// - Counter mode counts count-input falling edges
// - Edge recognition takes two machine cycles
// - Run bits start channel zero and one
// - Gate set: count only while gate high
// - Gate clear: run bit alone enables counting
// - Counter-select one counts edges, zero times
// - Mode 00 13-bit, 01 16-bit, 10 reload
// - Channel one mode 11 holds its count
// - Channel zero mode 11 splits two bytes
// - Count bytes readable and loadable by software
// - Count and gate inputs routed from user pins
// - 13-bit mode: high byte plus low five bits
// - Reload mode: low overflow reloads from high
// - Split high byte uses run one, flag one
// - Overflow sets flag; software or service clears
package dual_timer_pkg;
   localparam int unsigned MC_CLOCKS = 12;
   localparam logic [7:0] IDX_CONTROL = 8'h88;
   localparam logic [7:0] IDX_MODE = 8'h89;
   localparam logic [7:0] IDX_LOW0 = 8'h8A;
   localparam logic [7:0] IDX_LOW1 = 8'h8B;
   localparam logic [7:0] IDX_HIGH0 = 8'h8C;
   localparam logic [7:0] IDX_HIGH1 = 8'h8D;
   localparam logic [7:0] IDX_PINSEL = 8'h8E;
   localparam int unsigned CTL_FLAG1 = 7;
   localparam int unsigned CTL_RUN1 = 6;
   localparam int unsigned CTL_FLAG0 = 5;
   localparam int unsigned CTL_RUN0 = 4;
   localparam int unsigned NIB_CH1 = 4;
   localparam int unsigned NIB_GATE = 3;
   localparam int unsigned NIB_CT = 2;
   localparam int unsigned NIB_MODE = 0;
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [11:0] PINSEL_RESET = 12'h688;
   localparam int unsigned SEL_COUNT0 = 0;
   localparam int unsigned SEL_COUNT1 = 3;
   localparam int unsigned SEL_GATE0 = 6;
   localparam int unsigned SEL_GATE1 = 9;
endpackage

// ==== verilog/machine_cycle_tick.sv ====
// Divider giving one enable pulse per machine cycle
`timescale 1ns/1ps
module machine_cycle_tick
   import dual_timer_pkg::*;
#(
   parameter int unsigned DIVIDE = MC_CLOCKS
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   output logic tick_out
);
   typedef struct packed {
      logic [7:0] cnt_ff;
      logic tick_ff;
   } tick_state_t;
   tick_state_t s_ff;
   tick_state_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick_ff = 1'b0;
      if (s_ff.cnt_ff == 8'(DIVIDE - 1)) begin
         nxt_s.cnt_ff = 8'h00;
         nxt_s.tick_ff = 1'b1;
      end else begin
         nxt_s.cnt_ff = s_ff.cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tick_out = s_ff.tick_ff;
endmodule

// ==== verilog/fall_edge_sampler.sv ====
// Per-cycle sampler flagging high-to-low steps on the count inputs
`timescale 1ns/1ps
module fall_edge_sampler #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic tick_in,
   input wire logic [WIDTH-1:0] level_in,
   output logic [WIDTH-1:0] fall_out
);
   typedef struct packed {
      logic [WIDTH-1:0] prev_ff;
      logic [WIDTH-1:0] fall_ff;
   } edge_state_t;
   edge_state_t s_ff;
   edge_state_t nxt_s;

   // One sample per machine cycle: a fall needs a high then a low sample
   always_comb begin
      nxt_s = s_ff;
      nxt_s.fall_ff = '0;
      if (tick_in) begin
         nxt_s.prev_ff = level_in;
         nxt_s.fall_ff = s_ff.prev_ff & ~level_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign fall_out = s_ff.fall_ff;
endmodule

// ==== verilog/dual_timer_counter.sv ====
// Two-channel timer/counter with Avalon-MM register access
`timescale 1ns/1ps
module dual_timer_counter
   import dual_timer_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [9:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [3:0] byteenable_in,
   input wire logic [31:0] writedata_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic [7:0] user_port_pins_in,
   input wire logic [1:0] service_ack_in,
   output logic overflow_flag_zero_out,
   output logic overflow_flag_one_out
);
   typedef struct packed {
      logic [7:0] mode_ff;
      logic run_bit_zero_ff;
      logic run_bit_one_ff;
      logic flag_zero_ff;
      logic flag_one_ff;
      logic [7:0] low0_ff;
      logic [7:0] high0_ff;
      logic [7:0] low1_ff;
      logic [7:0] high1_ff;
      logic [11:0] pinsel_ff;
      logic wait_ff;
      logic [31:0] rdata_ff;
   } timer_state_t;
   timer_state_t s_ff;
   timer_state_t nxt_s;

   logic tick;
   logic [1:0] count_pins;
   logic [1:0] gate_pins;
   logic [1:0] falls;

   // Low byte, high byte and overflow after one count step
   function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0] s8;
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8 = {1'b0, lo} + 9'h001;
      case (m)
         MODE_13BIT: begin
            // Upper three low bits are left as they are
            step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
         end
         MODE_16BIT: begin
            step = s16;
         end
         MODE_RELOAD: begin
            step = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
         end
         default: begin
            step = {s8[8], hi, s8[7:0]};
         end
      endcase
   endfunction

   machine_cycle_tick #(
      .DIVIDE(MC_CLOCKS)
   ) u_tick (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tick_out(tick)
   );

   // Pins are chosen by software so any user pin can drive a channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_route
      localparam int unsigned CNT_POS = (ch == 0) ? SEL_COUNT0 : SEL_COUNT1;
      localparam int unsigned GATE_POS = (ch == 0) ? SEL_GATE0 : SEL_GATE1;
      assign count_pins[ch] = user_port_pins_in[s_ff.pinsel_ff[CNT_POS +: 3]];
      assign gate_pins[ch] = user_port_pins_in[s_ff.pinsel_ff[GATE_POS +: 3]];
   end

   fall_edge_sampler #(
      .WIDTH(2)
   ) u_edge (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .level_in(count_pins),
      .fall_out(falls)
   );

   always_comb begin
      logic [3:0] nib0;
      logic [3:0] nib1;
      logic gate_pin0;
      logic gate_pin1;
      logic en0;
      logic en1;
      logic en_hi0;
      logic split;
      logic set0;
      logic set1;
      logic [16:0] r0;
      logic [16:0] r1;
      logic [8:0] rh;
      logic [7:0] idx;
      logic wr;
      logic [7:0] wd;
      nib0 = s_ff.mode_ff[3:0];
      nib1 = s_ff.mode_ff[NIB_CH1 +: 4];
      gate_pin0 = gate_pins[0];
      gate_pin1 = gate_pins[1];
      split = (nib0[NIB_MODE +: 2] == MODE_SPLIT);
      idx = address_in[9:2];
      wr = write_in && !s_ff.wait_ff && byteenable_in[0];
      wd = writedata_in[7:0];
      set0 = 1'b0;
      set1 = 1'b0;
      nxt_s = s_ff;
      en0 = 1'b0;
      en1 = 1'b0;
      en_hi0 = 1'b0;
      r0 = 17'h00000;
      r1 = 17'h00000;
      rh = 9'h000;

      // Enable: run bit, optional gate, then timer tick or input edge
      en0 = s_ff.run_bit_zero_ff
         && (!nib0[NIB_GATE] || gate_pin0)
         && (nib0[NIB_CT] ? falls[0] : tick);
      en1 = s_ff.run_bit_one_ff
         && (!nib1[NIB_GATE] || gate_pin1)
         && (nib1[NIB_CT] ? falls[1] : tick)
         && (nib1[NIB_MODE +: 2] != MODE_SPLIT);
      en_hi0 = split && s_ff.run_bit_one_ff && tick;

      r0 = step(nib0[NIB_MODE +: 2], s_ff.low0_ff, s_ff.high0_ff);
      r1 = step(nib1[NIB_MODE +: 2], s_ff.low1_ff, s_ff.high1_ff);
      rh = {1'b0, s_ff.high0_ff} + 9'h001;

      if (en0) begin
         nxt_s.low0_ff = r0[7:0];
         if (!split) begin
            nxt_s.high0_ff = r0[15:8];
         end
         set0 = r0[16];
      end
      if (en_hi0) begin
         nxt_s.high0_ff = rh[7:0];
         set1 = rh[8];
      end
      if (en1) begin
         nxt_s.low1_ff = r1[7:0];
         nxt_s.high1_ff = r1[15:8];
         // With channel zero split, channel one raises no flag
         if (!split) begin
            set1 = r1[16];
         end
      end

      // Software load wins over a same-cycle count step
      if (wr) begin
         case (idx)
            IDX_CONTROL: begin
               nxt_s.run_bit_one_ff = wd[CTL_RUN1];
               nxt_s.run_bit_zero_ff = wd[CTL_RUN0];
               nxt_s.flag_one_ff = wd[CTL_FLAG1];
               nxt_s.flag_zero_ff = wd[CTL_FLAG0];
            end
            IDX_MODE: begin
               nxt_s.mode_ff = wd;
            end
            IDX_LOW0: begin
               nxt_s.low0_ff = wd;
            end
            IDX_LOW1: begin
               nxt_s.low1_ff = wd;
            end
            IDX_HIGH0: begin
               nxt_s.high0_ff = wd;
            end
            IDX_HIGH1: begin
               nxt_s.high1_ff = wd;
            end
            IDX_PINSEL: begin
               // Upper selector bits sit in the second byte lane
               nxt_s.pinsel_ff[7:0] = wd;
               if (byteenable_in[1]) begin
                  nxt_s.pinsel_ff[11:8] = writedata_in[11:8];
               end
            end
            default: begin
            end
         endcase
      end

      // Service clears the flag, but a fresh overflow wins
      if (service_ack_in[0]) begin
         nxt_s.flag_zero_ff = 1'b0;
      end
      if (service_ack_in[1]) begin
         nxt_s.flag_one_ff = 1'b0;
      end
      nxt_s.flag_zero_ff = nxt_s.flag_zero_ff | set0;
      nxt_s.flag_one_ff = nxt_s.flag_one_ff | set1;

      // One wait cycle: data latched on the first edge, taken on the second
      if (read_in || write_in) begin
         nxt_s.wait_ff = !s_ff.wait_ff;
      end else begin
         nxt_s.wait_ff = 1'b1;
      end
      if ((read_in || write_in) && s_ff.wait_ff) begin
         case (idx)
            IDX_CONTROL: begin
               nxt_s.rdata_ff = {24'h000000, s_ff.flag_one_ff, s_ff.run_bit_one_ff,
                  s_ff.flag_zero_ff, s_ff.run_bit_zero_ff, 4'h0};
            end
            IDX_MODE: begin
               nxt_s.rdata_ff = {24'h000000, s_ff.mode_ff};
            end
            IDX_LOW0: begin
               nxt_s.rdata_ff = {24'h000000, s_ff.low0_ff};
            end
            IDX_LOW1: begin
               nxt_s.rdata_ff = {24'h000000, s_ff.low1_ff};
            end
            IDX_HIGH0: begin
               nxt_s.rdata_ff = {24'h000000, s_ff.high0_ff};
            end
            IDX_HIGH1: begin
               nxt_s.rdata_ff = {24'h000000, s_ff.high1_ff};
            end
            IDX_PINSEL: begin
               nxt_s.rdata_ff = {20'h00000, s_ff.pinsel_ff};
            end
            default: begin
               nxt_s.rdata_ff = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_ff.mode_ff <= MODE_RESET;
         s_ff.run_bit_zero_ff <= 1'b0;
         s_ff.run_bit_one_ff <= 1'b0;
         s_ff.flag_zero_ff <= 1'b0;
         s_ff.flag_one_ff <= 1'b0;
         s_ff.low0_ff <= COUNT_RESET;
         s_ff.high0_ff <= COUNT_RESET;
         s_ff.low1_ff <= COUNT_RESET;
         s_ff.high1_ff <= COUNT_RESET;
         s_ff.pinsel_ff <= PINSEL_RESET;
         s_ff.wait_ff <= 1'b1;
         s_ff.rdata_ff <= 32'h00000000;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign readdata_out = s_ff.rdata_ff;
   assign waitrequest_out = s_ff.wait_ff;
   assign overflow_flag_zero_out = s_ff.flag_zero_ff;
   assign overflow_flag_one_out = s_ff.flag_one_ff;
endmodule

// ==== testbench/dual_timer_counter_monitor.sv ====
// Port-level assertions for the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_monitor
   import dual_timer_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [9:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] readdata_out,
   input wire logic waitrequest_out,
   input wire logic [1:0] service_ack_in,
   input wire logic overflow_flag_zero_out,
   input wire logic overflow_flag_one_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic wr_done;
   logic clear1;
   // Software write lands only at the answering edge
   assign wr_done = write_in && !waitrequest_out;
   assign clear1 = service_ack_in[1] || wr_done;
   property p_answer; (read_in || write_in) && waitrequest_out |=> !waitrequest_out; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_one_wait; !waitrequest_out |=> waitrequest_out; endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait low too long");
   // Selector register is twelve bits wide; all others fill the low byte
   property p_upper; !waitrequest_out |-> readdata_out[31:12] == 20'h0
      && (address_in[9:2] == IDX_PINSEL || readdata_out[11:8] == 4'h0); endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_unmapped; read_in && waitrequest_out && (address_in[9:2] < IDX_CONTROL ||
      address_in[9:2] > IDX_PINSEL) |=> readdata_out == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_hold; !read_in && !write_in |=> $stable(readdata_out); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_flag0_hold; overflow_flag_zero_out && !service_ack_in[0] && !wr_done
      |=> overflow_flag_zero_out; endproperty
   a_flag0_hold: assert property (p_flag0_hold) else $error("flag zero lost");
   property p_flag1_drop; $fell(overflow_flag_one_out)
      |-> $past(clear1); endproperty
   a_flag1_drop: assert property (p_flag1_drop) else $error("flag one lost");
   property p_flags_read; read_in && waitrequest_out && address_in[9:2] == IDX_CONTROL
      |=> readdata_out[7] == $past(overflow_flag_one_out) && readdata_out[3:0] == 4'h0
      && readdata_out[5] == $past(overflow_flag_zero_out); endproperty
   a_flags_read: assert property (p_flags_read) else $error("flag readback");
endmodule
bind dual_timer_counter dual_timer_counter_monitor mon (.clk_in(clk_in), .nrst_in(nrst_in),
   .address_in(address_in), .read_in(read_in), .write_in(write_in),
   .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
   .service_ack_in(service_ack_in), .overflow_flag_zero_out(overflow_flag_zero_out),
   .overflow_flag_one_out(overflow_flag_one_out));

// ==== testbench/pin_source.sv ====
// Model of the count and gate pins feeding the timer block
`timescale 1ns/1ps
module pin_source #(
   parameter int unsigned HALF = 12
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic run_in,
   input wire logic [1:0] gate_in,
   output logic [7:0] pins_out,
   output logic [7:0] falls_out
);
   logic [7:0] cnt_ff;
   logic level_ff;
   // Levels change only on slot ends, so each is seen once
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_ff <= 8'h00;
         level_ff <= 1'h1;
         falls_out <= 8'h00;
      end else if (cnt_ff == 8'(HALF - 1)) begin
         cnt_ff <= 8'h00;
         level_ff <= run_in ? ~level_ff : 1'h1;
         if (level_ff && run_in) falls_out <= falls_out + 8'h01;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
   // Unused pins wander so no one relies on them
   assign pins_out = {cnt_ff[3:0], gate_in, level_ff, level_ff};
endmodule

// ==== testbench/test_dual_timer_counter.sv ====
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module test_dual_timer_counter;
   import dual_timer_pkg::*;
   logic clk_in = 1'h0, nrst_in = 1'h0, read_in = 1'h0, write_in = 1'h0, run_p = 1'h0;
   logic [9:0] address_in = 10'h000;
   logic [31:0] writedata_in = 32'h0, readdata_out, rd;
   logic waitrequest_out, f0, f1;
   logic [1:0] ack = 2'h0, gate = 2'h0;
   logic [7:0] pins, falls, base, n;
   int mismatches = 0, check_count = 0, c;
   always #50 clk_in = ~clk_in;
   dual_timer_counter uut (.clk_in(clk_in), .nrst_in(nrst_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .byteenable_in(4'hF),
      .writedata_in(writedata_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .user_port_pins_in(pins), .service_ack_in(ack),
      .overflow_flag_zero_out(f0), .overflow_flag_one_out(f1));
   pin_source src (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(run_p), .gate_in(gate),
      .pins_out(pins), .falls_out(falls));
   task automatic conclude();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_in);
      address_in <= {idx, 2'h0};
      writedata_in <= {24'h0, d};
      write_in <= wr;
      read_in <= !wr;
      do @(posedge clk_in); while (waitrequest_out !== 1'h0);
      rd = readdata_out;
      write_in <= 1'h0;
      read_in <= 1'h0;
   endtask
   task automatic start(input logic [7:0] m, lo, hi, ctl);
      // Stop first so a channel left running cannot step mid-load
      bus(1'h1, IDX_CONTROL, 8'h00);
      bus(1'h1, IDX_MODE, m);
      bus(1'h1, IDX_LOW0, lo);
      bus(1'h1, IDX_HIGH0, hi);
      bus(1'h1, IDX_CONTROL, ctl);
   endtask
   task automatic wait_flag(input logic sel);
      c = 0;
      while ((sel ? f1 : f0) !== 1'h1 && c < 40) begin
         @(posedge clk_in);
         c++;
      end
   endtask
   // Long settle so the two-cycle edge lag has passed
   task automatic pulses();
      run_p <= 1'h1;
      repeat (96) @(posedge clk_in);
      run_p <= 1'h0;
      repeat (60) @(posedge clk_in);
      bus(1'h0, IDX_LOW0, 8'h00);
   endtask
   task automatic t_reset();
      bus(1'h0, IDX_PINSEL, 8'h00);
      `CHK(rd, 32'h688)
      bus(1'h0, 8'h20, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'h1, IDX_MODE, 8'hA5);
      bus(1'h0, IDX_MODE, 8'h00);
      `CHK(rd, 32'hA5)
      $display("done reset");
   endtask
   task automatic t_timer();
      start(8'h01, 8'hFE, 8'hFF, 8'h10);
      wait_flag(1'h0);
      `CHK(c inside {[13:25]}, 1'h1)
      bus(1'h0, IDX_HIGH0, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'h0, IDX_CONTROL, 8'h00);
      `CHK(rd, 32'h30)
      ack <= 2'h1;
      @(posedge clk_in);
      ack <= 2'h0;
      @(posedge clk_in);
      `CHK(f0, 1'h0)
      $display("done timer");
   endtask
   task automatic t_mode13();
      start(8'h00, 8'h1E, 8'hFF, 8'h10);
      wait_flag(1'h0);
      `CHK(c inside {[13:25]}, 1'h1)
      bus(1'h1, IDX_CONTROL, 8'h00);
      bus(1'h0, IDX_HIGH0, 8'h00);
      `CHK(rd, 32'h0)
      `CHK(f0, 1'h0)
      $display("done mode13");
   endtask
   task automatic t_reload();
      start(8'h02, 8'hFF, 8'hF0, 8'h10);
      wait_flag(1'h0);
      `CHK(c inside {[2:13]}, 1'h1)
      bus(1'h1, IDX_CONTROL, 8'h00);
      bus(1'h0, IDX_LOW0, 8'h00);
      `CHK(rd inside {32'hF0, 32'hF1}, 1'h1)
      bus(1'h0, IDX_HIGH0, 8'h00);
      `CHK(rd, 32'hF0)
      $display("done reload");
   endtask
   task automatic t_chan1();
      bus(1'h1, IDX_CONTROL, 8'h00);
      bus(1'h1, IDX_MODE, 8'h10);
      bus(1'h1, IDX_LOW1, 8'hFE);
      bus(1'h1, IDX_HIGH1, 8'hFF);
      bus(1'h1, IDX_CONTROL, 8'h40);
      wait_flag(1'h1);
      `CHK(c inside {[13:25]}, 1'h1)
      `CHK(f0, 1'h0)
      ack <= 2'h2;
      @(posedge clk_in);
      ack <= 2'h0;
      @(posedge clk_in);
      `CHK(f1, 1'h0)
      bus(1'h1, IDX_CONTROL, 8'h00);
      bus(1'h0, IDX_HIGH1, 8'h00);
      `CHK(rd, 32'h0)
      $display("done chan1");
   endtask
   task automatic t_counter();
      gate <= 2'h3;
      start(8'h0D, 8'h00, 8'h00, 8'h10);
      base = falls;
      pulses();
      n = falls - base;
      `CHK(rd, {24'h0, n})
      gate <= 2'h0;
      pulses();
      `CHK(rd, {24'h0, n})
      bus(1'h1, IDX_MODE, 8'h05);
      base = falls;
      pulses();
      `CHK(rd, {24'h0, 8'(n + falls - base)})
      bus(1'h1, IDX_CONTROL, 8'h00);
      $display("done counter");
   endtask
   task automatic t_split();
      bus(1'h1, IDX_LOW1, 8'h55);
      start(8'h33, 8'h00, 8'hFE, 8'h40);
      wait_flag(1'h1);
      `CHK(c inside {[13:25]}, 1'h1)
      bus(1'h0, IDX_LOW0, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'h0, IDX_LOW1, 8'h00);
      `CHK(rd, 32'h55)
      bus(1'h1, IDX_CONTROL, 8'h00);
      $display("done split");
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'h1;
      t_reset();
      t_timer();
      t_mode13();
      t_reload();
      t_chan1();
      t_counter();
      t_split();
      conclude();
   end
   initial begin
      #600000;
      mismatches++;
      conclude();
   end
endmodule
